/* itab_pkg.sv */
// Shared constants and types for the indirect table access block.
// Assumes a 32-bit Avalon-MM register bus with byte addressing and a
// single 200 MHz clock with a synchronous active-high reset.
package itab_pkg;

  // ----------------------------------------------------------------
  // Register map: indexes; the byte address is four times the index
  // ----------------------------------------------------------------
  localparam int          ITAB_ADDR_W   = 8;
  localparam logic [5:0]  IDX_CMD       = 6'h00;
  localparam logic [5:0]  IDX_TOP       = 6'h02;
  localparam logic [5:0]  IDX_WORD2     = 6'h04;
  localparam logic [5:0]  IDX_WORD3     = 6'h06;
  localparam logic [5:0]  IDX_WORD0     = 6'h08;
  localparam logic [5:0]  IDX_WORD1     = 6'h0a;
  localparam logic [5:0]  IDX_IRQ_STAT  = 6'h0c;
  localparam logic [5:0]  IDX_IRQ_MASK  = 6'h0e;

  // ----------------------------------------------------------------
  // Command word, top register and entry fields
  // ----------------------------------------------------------------
  localparam int          CMD_RD_BIT    = 12;
  localparam int          CMD_SEL_LSB   = 10;
  localparam int          CMD_ADDR_W    = 10;
  localparam int          TOP_BUSY_BIT  = 7;
  localparam int          TOP_DATA_W    = 3;
  localparam int          ENTRY_W       = 67;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] CMD_RST       = 16'h0000;
  localparam logic [15:0] WORD_RST      = 16'h0000;
  localparam logic [2:0]  TOP_RST       = 3'h0;

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  localparam int          EV_RD_DONE    = 0;
  localparam int          EV_WR_DONE    = 1;
  localparam int          EV_NUM        = 2;

  // Table selected by the two-bit field of the command word
  typedef enum logic [1:0] {
    TBL_STATIC = 2'h0,
    TBL_VLAN   = 2'h1,
    TBL_DYN    = 2'h2,
    TBL_MIB    = 2'h3
  } itab_tbl_e;

  // Transfer engine states
  typedef enum logic [1:0] {
    XF_IDLE = 2'b01,
    XF_WAIT = 2'b10
  } itab_xf_e;

endpackage : itab_pkg

/* itab_xfer.sv */
// Transfer engine: carries one command to the table storage and waits.
// Assumes the storage answers each request with a one-cycle ack.
`timescale 1ns/1ps
module itab_xfer
  import itab_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  start,
  input  wire logic                  start_rd,
  input  wire logic [1:0]            start_sel,
  input  wire logic [CMD_ADDR_W-1:0] start_addr,
  input  wire logic [ENTRY_W-1:0]    start_wdata,
  output logic                       busy,
  output logic                       done,
  output logic                       done_rd,
  output logic                       tbl_req,
  output logic                       tbl_rd,
  output logic [1:0]                 tbl_sel,
  output logic [CMD_ADDR_W-1:0]      tbl_addr,
  output logic [ENTRY_W-1:0]         tbl_wdata,
  input  wire logic                  tbl_ack
);

  typedef struct packed {
    itab_xf_e               st;
    logic                   rd;
    logic [1:0]             sel;
    logic [CMD_ADDR_W-1:0]  addr;
    logic [ENTRY_W-1:0]     wdata;
    logic                   done;
    logic                   done_rd;
  } itab_xf_s;

  itab_xf_s xf_r;
  itab_xf_s xf_nxt;

  // Latch the command on start, finish on ack
  always_comb begin
    xf_nxt         = xf_r;
    xf_nxt.done    = 1'b0;
    xf_nxt.done_rd = 1'b0;
    case (xf_r.st)
      XF_IDLE: begin
        if (start) begin
          xf_nxt.st    = XF_WAIT;
          xf_nxt.rd    = start_rd;
          xf_nxt.sel   = start_sel;
          xf_nxt.addr  = start_addr;
          xf_nxt.wdata = start_wdata;
        end
      end
      XF_WAIT: begin
        if (tbl_ack) begin
          xf_nxt.st      = XF_IDLE;
          xf_nxt.done    = 1'b1;
          xf_nxt.done_rd = xf_r.rd;
        end
      end
      default: xf_nxt.st = XF_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      xf_r <= '{st: XF_IDLE, sel: 2'h0, addr: '0, wdata: '0, default: 1'b0};
    end else begin
      xf_r <= xf_nxt;
    end
  end

  assign busy      = (xf_r.st == XF_WAIT);
  assign tbl_req   = (xf_r.st == XF_WAIT);
  assign tbl_rd    = xf_r.rd;
  assign tbl_sel   = xf_r.sel;
  assign tbl_addr  = xf_r.addr;
  assign tbl_wdata = xf_r.wdata;
  assign done      = xf_r.done;
  assign done_rd   = xf_r.done_rd;

endmodule : itab_xfer

/* itab_irq.sv */
// Sticky event status with write-one-to-clear and a mask register.
// Assumes clear and mask strobes are one-cycle pulses from the bus slave.
`timescale 1ns/1ps
module itab_irq #(
  parameter int N = 2
) (
  input  wire logic         clk,
  input  wire logic         reset,
  input  wire logic [N-1:0] ev_set,
  input  wire logic         clr_wr,
  input  wire logic [N-1:0] clr_bits,
  input  wire logic         mask_wr,
  input  wire logic [N-1:0] mask_bits,
  output logic [N-1:0]      status,
  output logic [N-1:0]      mask,
  output logic              irq
);

  typedef struct packed {
    logic [N-1:0] stat;
    logic [N-1:0] mask;
  } itab_irq_s;

  itab_irq_s ir_r;
  itab_irq_s ir_nxt;

  // A set in the same cycle as its clear wins, so no event is lost
  always_comb begin
    ir_nxt = ir_r;
    if (clr_wr) begin
      ir_nxt.stat = ir_r.stat & ~clr_bits;
    end
    ir_nxt.stat = ir_nxt.stat | ev_set;
    if (mask_wr) begin
      ir_nxt.mask = mask_bits;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      ir_r <= '0;
    end else begin
      ir_r <= ir_nxt;
    end
  end

  assign status = ir_r.stat;
  assign mask   = ir_r.mask;
  assign irq    = |(ir_r.stat & ir_r.mask);

endmodule : itab_irq

/* itab_top.sv */
// Indirect table access register bank with an Avalon-MM slave port.
// Assumes the lookup tables and counters answer a held request with a
// one-cycle ack, returning read data in the ack cycle.
`timescale 1ns/1ps
// How it works
// (R01) Writing the command register launches a transfer
// (R02) Command bit 12: one reads, zero writes
// (R03) Bits 11-10 pick static, VLAN, dynamic, counters
// (R04) Bits 9-0 give the table entry index
// (R05) Busy bit 7 during dynamic or counter reads
// (R06) Top register: data 66-64, busy, else zero
// (R07) Word0 holds bits 15-0, word1 bits 31-16
// (R08) Word2 holds bits 47-32, word3 bits 63-48
// (R09) Software loads data first, polls busy after
// (R10) Reset clears command, data and busy flag
module itab_top
  import itab_pkg::*;
(
  input  wire logic                   clk,
  input  wire logic                   reset,
  input  wire logic [ITAB_ADDR_W-1:0] address,
  input  wire logic                   read,
  input  wire logic                   write,
  input  wire logic [3:0]             byteenable,
  input  wire logic [31:0]            writedata,
  output logic [31:0]                 readdata,
  output logic                        waitrequest,
  output logic                        irq,
  output logic                        tbl_req,
  output logic                        tbl_rd,
  output logic [1:0]                  tbl_sel,
  output logic [CMD_ADDR_W-1:0]       tbl_addr,
  output logic [ENTRY_W-1:0]          tbl_wdata,
  input  wire logic                   tbl_ack,
  input  wire logic [ENTRY_W-1:0]     tbl_rdata
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [15:0]           cmd;
    logic [15:0]           word0;
    logic [15:0]           word1;
    logic [15:0]           word2;
    logic [15:0]           word3;
    logic [TOP_DATA_W-1:0] top;
    logic                  pend;
    logic                  ack;
    logic                  start;
    logic [31:0]           rdata;
  } itab_regs_s;

  itab_regs_s rg_r;
  itab_regs_s rg_nxt;

  logic              xf_busy;
  logic              xf_done;
  logic              xf_done_rd;
  logic              active;
  logic [5:0]        idx;
  logic              wr_take;
  logic              rd_take;
  logic [EV_NUM-1:0] ev_set;
  logic [EV_NUM-1:0] irq_status;
  logic [EV_NUM-1:0] irq_mask;
  logic [15:0]       top_view;
  logic              tbl_fin;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Merge the two low byte lanes into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0]  be);
    logic [15:0] res;
    res = old;
    if (be[0]) begin
      res[7:0] = wd[7:0];
    end
    if (be[1]) begin
      res[15:8] = wd[15:8];
    end
    return res;
  endfunction : merge16

  // Busy only applies to reads of the dynamic table or the counters
  function automatic logic needs_busy(input logic [15:0] c);
    itab_tbl_e t;
    t = itab_tbl_e'(c[CMD_SEL_LSB+1:CMD_SEL_LSB]);
    return c[CMD_RD_BIT] && ((t == TBL_DYN) || (t == TBL_MIB));
  endfunction : needs_busy

  // ----------------------------------------------------------------
  // Bus decode and handshake
  // ----------------------------------------------------------------
  // Every access waits one cycle; writes also wait while a transfer
  // runs, so the staged entry cannot change under the tables.
  assign idx         = address[ITAB_ADDR_W-1:2];
  assign active      = rg_r.start | xf_busy;
  assign waitrequest = (read | write) & ~rg_r.ack;
  assign wr_take     = write & rg_r.ack;
  assign rd_take     = read & rg_r.ack;
  assign readdata    = rg_r.rdata;

  // The tables answer once per request; their data stands only then
  assign tbl_fin     = tbl_req & tbl_ack;

  // Status view of the top data register
  always_comb begin
    top_view                    = 16'h0000;
    top_view[TOP_DATA_W-1:0]    = rg_r.top; // R06
    top_view[TOP_BUSY_BIT]      = rg_r.pend; // R05
  end

  // ----------------------------------------------------------------
  // Register next state
  // ----------------------------------------------------------------
  always_comb begin
    rg_nxt       = rg_r;
    rg_nxt.start = 1'b0;
    rg_nxt.ack   = (read | (write & ~active)) & ~rg_r.ack;

    // Read data is captured one edge before the answer edge
    if (read & ~rg_r.ack) begin
      case (idx)
        IDX_CMD:      rg_nxt.rdata = {16'h0000, rg_r.cmd};
        IDX_TOP:      rg_nxt.rdata = {16'h0000, top_view}; // R06
        IDX_WORD2:    rg_nxt.rdata = {16'h0000, rg_r.word2}; // R08
        IDX_WORD3:    rg_nxt.rdata = {16'h0000, rg_r.word3}; // R08
        IDX_WORD0:    rg_nxt.rdata = {16'h0000, rg_r.word0}; // R07
        IDX_WORD1:    rg_nxt.rdata = {16'h0000, rg_r.word1}; // R07
        IDX_IRQ_STAT: rg_nxt.rdata = {{(32-EV_NUM){1'b0}}, irq_status};
        IDX_IRQ_MASK: rg_nxt.rdata = {{(32-EV_NUM){1'b0}}, irq_mask};
        default:      rg_nxt.rdata = 32'h0000_0000;
      endcase
    end

    // Writes take effect only at the answer edge
    if (wr_take) begin
      case (idx)
        IDX_CMD: begin
          rg_nxt.cmd   = merge16(rg_r.cmd, writedata, byteenable);
          rg_nxt.start = 1'b1; // R01
          rg_nxt.pend  = needs_busy(rg_nxt.cmd); // R05
        end
        IDX_WORD2: rg_nxt.word2 = merge16(rg_r.word2, writedata, byteenable); // R08
        IDX_WORD3: rg_nxt.word3 = merge16(rg_r.word3, writedata, byteenable); // R08
        IDX_WORD0: rg_nxt.word0 = merge16(rg_r.word0, writedata, byteenable); // R07
        IDX_WORD1: rg_nxt.word1 = merge16(rg_r.word1, writedata, byteenable); // R07
        default: ;
      endcase
    end

    // Read data stands only in the ack cycle; busy drops with the load
    if (tbl_fin && tbl_rd) begin
      rg_nxt.word0 = tbl_rdata[15:0]; // R07
      rg_nxt.word1 = tbl_rdata[31:16]; // R07
      rg_nxt.word2 = tbl_rdata[47:32]; // R08
      rg_nxt.word3 = tbl_rdata[63:48]; // R08
      rg_nxt.top   = tbl_rdata[66:64]; // R06
    end
    if (tbl_fin) begin
      rg_nxt.pend = 1'b0; // R05
    end
  end

  // Synchronous reset clears command, data and busy flag
  always_ff @(posedge clk) begin
    if (reset) begin
      rg_r <= '{cmd: CMD_RST, word0: WORD_RST, word1: WORD_RST,
                word2: WORD_RST, word3: WORD_RST, top: TOP_RST,
                pend: 1'b0, ack: 1'b0, start: 1'b0,
                rdata: 32'h0000_0000}; // R10
    end else begin
      rg_r <= rg_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Transfer engine
  // ----------------------------------------------------------------
  // The command word is split into direction, table and index here
  itab_xfer u_xfer (
    .clk         (clk),
    .reset       (reset),
    .start       (rg_r.start), // R01
    .start_rd    (rg_r.cmd[CMD_RD_BIT]), // R02
    .start_sel   (rg_r.cmd[CMD_SEL_LSB+1:CMD_SEL_LSB]), // R03
    .start_addr  (rg_r.cmd[CMD_ADDR_W-1:0]), // R04
    .start_wdata ({rg_r.top, rg_r.word3, rg_r.word2, rg_r.word1, rg_r.word0}),
    .busy        (xf_busy),
    .done        (xf_done),
    .done_rd     (xf_done_rd),
    .tbl_req     (tbl_req),
    .tbl_rd      (tbl_rd),
    .tbl_sel     (tbl_sel),
    .tbl_addr    (tbl_addr),
    .tbl_wdata   (tbl_wdata),
    .tbl_ack     (tbl_ack)
  );

  // ----------------------------------------------------------------
  // Interrupts
  // ----------------------------------------------------------------
  always_comb begin
    ev_set             = '0;
    ev_set[EV_RD_DONE] = xf_done & xf_done_rd;
    ev_set[EV_WR_DONE] = xf_done & ~xf_done_rd;
  end

  itab_irq #(
    .N (EV_NUM)
  ) u_irq (
    .clk       (clk),
    .reset     (reset),
    .ev_set    (ev_set),
    .clr_wr    (wr_take && (idx == IDX_IRQ_STAT) && byteenable[0]),
    .clr_bits  (writedata[EV_NUM-1:0]),
    .mask_wr   (wr_take && (idx == IDX_IRQ_MASK) && byteenable[0]),
    .mask_bits (writedata[EV_NUM-1:0]),
    .status    (irq_status),
    .mask      (irq_mask),
    .irq       (irq)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // A taken command write starts the engine on the following edges
  a_cmd_launch: assert property (@(posedge clk) disable iff (reset) // R01
    (wr_take && idx == IDX_CMD) |=> rg_r.start ##1 tbl_req)
    else $error("command write did not launch a table request");

  // Direction on the table side follows the stored command
  a_dir_follow: assert property (@(posedge clk) disable iff (reset) // R02
    tbl_req |-> (tbl_rd == rg_r.cmd[CMD_RD_BIT]))
    else $error("table direction differs from command bit");

  // Table select follows the stored command
  a_tbl_select: assert property (@(posedge clk) disable iff (reset) // R03
    tbl_req |-> (tbl_sel == rg_r.cmd[CMD_SEL_LSB+1:CMD_SEL_LSB]))
    else $error("table select differs from command field");

  // Entry index follows the stored command
  a_entry_index: assert property (@(posedge clk) disable iff (reset) // R04
    tbl_req |-> (tbl_addr == rg_r.cmd[CMD_ADDR_W-1:0]))
    else $error("table index differs from command field");

  // Busy rises for a dynamic or counter read and holds into the first request cycle
  a_busy_set: assert property (@(posedge clk) disable iff (reset) // R05
    (wr_take && idx == IDX_CMD && writedata[CMD_RD_BIT]
     && writedata[CMD_SEL_LSB+1] && (&byteenable[1:0]))
    |=> rg_r.pend ##1 (rg_r.pend throughout (tbl_req [*1])))
    else $error("busy flag not held during pending read");

  // Busy never set for writes or static and VLAN reads
  a_busy_clear: assert property (@(posedge clk) disable iff (reset) // R05
    (xf_done || (tbl_req && !(tbl_rd && tbl_sel[1]))) |=> !rg_r.pend)
    else $error("busy flag set without a pending dynamic read");

  // Top register reads show only data, busy and zeros
  a_top_layout: assert property (@(posedge clk) disable iff (reset) // R06
    (rd_take && idx == IDX_TOP) |->
      (readdata[31:8] == 24'h000000 && readdata[6:3] == 4'h0))
    else $error("top data register shows reserved bits");

  // Read results land in the words in the documented order
  a_read_load: assert property (@(posedge clk) disable iff (reset) // R07
    (tbl_fin && tbl_rd) |=> ({rg_r.top, rg_r.word3, rg_r.word2, rg_r.word1, rg_r.word0}
                    == $past(tbl_rdata)))
    else $error("read data not placed in data words");

  // Write data toward the tables is assembled from the words
  a_write_data: assert property (@(posedge clk) disable iff (reset) // R08
    (tbl_req && !tbl_rd) |->
      (tbl_wdata == {rg_r.top, rg_r.word3, rg_r.word2, rg_r.word1, rg_r.word0}))
    else $error("table write data differs from data words");

  // A fresh read request waits exactly one cycle
  a_bus_answer: assert property (@(posedge clk) disable iff (reset)
    (read && !rg_r.ack) |-> waitrequest ##1 !waitrequest)
    else $error("read not answered after one wait cycle");

  // Reset leaves the command, word0, top data and busy flag clear
  a_reset_state: assert property (@(posedge clk) // R10
    $past(reset) |-> (rg_r.cmd == CMD_RST && rg_r.pend == 1'b0
                      && rg_r.word0 == WORD_RST && rg_r.top == TOP_RST))
    else $error("registers not cleared by reset");

  // Interrupt line tracks unmasked status
  a_irq_level: assert property (@(posedge clk) disable iff (reset)
    irq == |(irq_status & irq_mask))
    else $error("interrupt output disagrees with status and mask");

  // Busy drops at the edge that loads the read data
  a_busy_drop: assert property (@(posedge clk) disable iff (reset) // R05
    tbl_fin |=> !rg_r.pend)
    else $error("busy flag still set after table ack");

  // Writes wait while a transfer runs
  a_write_stall: assert property (@(posedge clk) disable iff (reset)
    (write && active) |-> waitrequest)
    else $error("write answered during a transfer");

  // Table request and its fields hold until the ack
  a_req_hold: assert property (@(posedge clk) disable iff (reset)
    (tbl_req && !tbl_ack) |=> (tbl_req && $stable(tbl_addr) && $stable(tbl_sel)
                               && $stable(tbl_rd) && $stable(tbl_wdata)))
    else $error("table request changed before its ack");

  // The top data bits ignore bus writes
  a_top_readonly: assert property (@(posedge clk) disable iff (reset) // R06
    (wr_take && idx == IDX_TOP) |=> (rg_r.top == $past(rg_r.top)))
    else $error("bus write changed the top data bits");

  // A full write to word0 lands as written
  a_word0_write: assert property (@(posedge clk) disable iff (reset) // R07
    (wr_take && idx == IDX_WORD0 && (&byteenable[1:0]))
    |=> (rg_r.word0 == $past(writedata[15:0])))
    else $error("word0 differs from written value");

  // A full write to word2 lands as written
  a_word2_write: assert property (@(posedge clk) disable iff (reset) // R08
    (wr_take && idx == IDX_WORD2 && (&byteenable[1:0]))
    |=> (rg_r.word2 == $past(writedata[15:0])))
    else $error("word2 differs from written value");

  // The command word is stored whole, reserved bits too
  a_cmd_store: assert property (@(posedge clk) disable iff (reset) // R01
    (wr_take && idx == IDX_CMD && (&byteenable[1:0]))
    |=> (rg_r.cmd == $past(writedata[15:0])))
    else $error("command differs from written value");

  // An event sets its status bit even under a clear
  a_status_set: assert property (@(posedge clk) disable iff (reset)
    (|ev_set) |=> ((irq_status & $past(ev_set)) == $past(ev_set)))
    else $error("event did not set its status bit");

endmodule : itab_top

/* itab_tbl_model.sv */
// Behavioural model of the lookup tables and counters behind the block.
// Assumes the bench sets ack_delay and rd_value before each transfer.
`timescale 1ns/1ps
module itab_tbl_model
  import itab_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  reset,
  input  wire logic                  tbl_req,
  input  wire logic                  tbl_rd,
  input  wire logic [1:0]            tbl_sel,
  input  wire logic [CMD_ADDR_W-1:0] tbl_addr,
  input  wire logic [ENTRY_W-1:0]    tbl_wdata,
  output logic                       tbl_ack,
  output logic [ENTRY_W-1:0]         tbl_rdata,
  input  wire logic [3:0]            ack_delay,
  input  wire logic [ENTRY_W-1:0]    rd_value,
  output logic                       seen_rd,
  output logic [1:0]                 seen_sel,
  output logic [CMD_ADDR_W-1:0]      seen_addr,
  output logic [ENTRY_W-1:0]         seen_wdata,
  output logic [7:0]                 seen_count
);
  logic [3:0] cnt;

  // One ack pulse per request, ack_delay+1 cycles after it rises; outside the ack
  // cycle the data lines flip so stale data never looks valid
  always_ff @(posedge clk) begin
    if (reset) begin
      cnt        <= 4'h0;
      tbl_ack    <= 1'b0;
      tbl_rdata  <= '0;
      seen_rd    <= 1'b0;
      seen_sel   <= 2'h0;
      seen_addr  <= '0;
      seen_wdata <= '0;
      seen_count <= 8'h00;
    end else begin
      tbl_ack <= 1'b0;
      if (tbl_ack) begin
        tbl_rdata <= ~tbl_rdata;
      end
      if (tbl_req && !tbl_ack) begin
        if (cnt >= ack_delay) begin
          tbl_ack    <= 1'b1;
          tbl_rdata  <= rd_value;
          cnt        <= 4'h0;
          seen_rd    <= tbl_rd;
          seen_sel   <= tbl_sel;
          seen_addr  <= tbl_addr;
          seen_wdata <= tbl_wdata;
          seen_count <= seen_count + 8'h01;
        end else begin
          cnt <= cnt + 4'h1;
        end
      end
    end
  end
endmodule : itab_tbl_model

/* indirect_table_access_tb_top.sv */
// Self-checking bench for the indirect table access register bank.
// Assumes the table model above answers every table request.
`timescale 1ns/1ps
module indirect_table_access_tb_top
  import itab_pkg::*;
;
  logic                   clk = 1'b0;
  logic                   reset = 1'b1;
  logic [ITAB_ADDR_W-1:0] address = '0;
  logic                   read = 1'b0;
  logic                   write = 1'b0;
  logic [31:0]            writedata = '0;
  logic [31:0]            readdata;
  logic                   waitrequest, irq, tbl_req, tbl_rd, tbl_ack, seen_rd;
  logic [1:0]             tbl_sel, seen_sel;
  logic [CMD_ADDR_W-1:0]  tbl_addr, seen_addr;
  logic [ENTRY_W-1:0]     tbl_wdata, tbl_rdata, seen_wdata;
  logic [ENTRY_W-1:0]     rd_value = '0;
  logic [3:0]             ack_delay = 4'h2;
  logic [7:0]             seen_count;
  logic [15:0]            w [4];
  logic [31:0]            q;
  logic [2:0]             top_exp;
  logic [9:0]             ea;
  int                     bad_count = 0;
  int                     n_checks = 0;
  int                     seed = 64667;
  int                     s, k;

  itab_top dut (.clk(clk), .reset(reset), .address(address), .read(read), .write(write),
    .byteenable(4'h3), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .tbl_req(tbl_req), .tbl_rd(tbl_rd),
    .tbl_sel(tbl_sel), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_ack(tbl_ack),
    .tbl_rdata(tbl_rdata));

  itab_tbl_model model (.clk(clk), .reset(reset), .tbl_req(tbl_req), .tbl_rd(tbl_rd),
    .tbl_sel(tbl_sel), .tbl_addr(tbl_addr), .tbl_wdata(tbl_wdata), .tbl_ack(tbl_ack),
    .tbl_rdata(tbl_rdata), .ack_delay(ack_delay), .rd_value(rd_value), .seen_rd(seen_rd),
    .seen_sel(seen_sel), .seen_addr(seen_addr), .seen_wdata(seen_wdata),
    .seen_count(seen_count));

  // 200 MHz clock
  always #2.5 clk = ~clk;

  // ----------------------------------------------------------------
  // Checking and bus tasks
  // ----------------------------------------------------------------
  task test_done();
    $display("Checks %0d, mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : test_done

  task chk_reg(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_reg

  task chk_ent(input string nm, input logic [66:0] e, input logic [66:0] g);
    n_checks++;
    if (g !== e) begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk_ent

  // Request held until waitrequest is sampled low; data taken at that edge
  task bus(input logic wr, input logic [7:0] a, input logic [15:0] d);
    int i;
    logic wr_low;
    @(posedge clk);
    address   <= a;
    read      <= !wr;
    write     <= wr;
    writedata <= {16'h0000, d};
    for (i = 0; i < 200; i++) begin
      @(negedge clk);
      wr_low = (waitrequest === 1'b0);
      q      = readdata;
      @(posedge clk);
      if (wr_low) break;
    end
    read  <= 1'b0;
    write <= 1'b0;
    if (i >= 200) begin
      chk_reg("waitrequest", 32'h0, 32'h1);
      test_done();
    end
  endtask : bus

  task wait_count(input logic [7:0] n);
    int i;
    for (i = 0; i < 200 && seen_count !== n; i++) @(posedge clk);
    if (i >= 200) begin
      chk_reg("table transfers", {24'h0, n}, {24'h0, seen_count});
      test_done();
    end
  endtask : wait_count

  task chk_words();
    bus(1'b0, 8'h20, 16'h0); chk_reg("word0", {16'h0, w[0]}, q);
    bus(1'b0, 8'h28, 16'h0); chk_reg("word1", {16'h0, w[1]}, q);
    bus(1'b0, 8'h10, 16'h0); chk_reg("word2", {16'h0, w[2]}, q);
    bus(1'b0, 8'h18, 16'h0); chk_reg("word3", {16'h0, w[3]}, q);
  endtask : chk_words

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (5) @(posedge clk);
    reset <= 1'b0;
    // Reset values of every register, plus an unmapped place
    for (k = 0; k < 8; k++) begin
      bus(1'b0, 8'(k * 8), 16'h0);
      chk_reg("reset value", 32'h0, q);
    end
    bus(1'b1, 8'h3c, 16'hffff);
    bus(1'b0, 8'h3c, 16'h0);
    chk_reg("unmapped", 32'h0, q);
    top_exp = 3'h0;
    // Table writes, one per table, data staged first
    for (s = 0; s < 4; s++) begin
      for (k = 0; k < 4; k++) w[k] = 16'($random(seed));
      ea        = 10'($random(seed));
      ack_delay <= 4'($random(seed) & 7);
      bus(1'b1, 8'h20, w[0]);
      bus(1'b1, 8'h28, w[1]);
      bus(1'b1, 8'h10, w[2]);
      bus(1'b1, 8'h18, w[3]);
      chk_words();
      bus(1'b1, 8'h00, {3'h5, 1'b0, 2'(s), ea});
      wait_count(8'(s + 1));
      chk_reg("direction", 32'h0, {31'h0, seen_rd});
      chk_reg("table", 32'(s), {30'h0, seen_sel});
      chk_reg("entry", {22'h0, ea}, {22'h0, seen_addr});
      chk_ent("entry data", {top_exp, w[3], w[2], w[1], w[0]}, seen_wdata);
      bus(1'b0, 8'h00, 16'h0);
      chk_reg("command", {16'h0, 3'h5, 1'b0, 2'(s), ea}, q);
    end
    // Table reads; busy shows only for dynamic and counter tables
    for (s = 0; s < 4; s++) begin
      rd_value  <= {3'($random(seed)), 32'($random(seed)), 32'($random(seed))};
      ack_delay <= 4'(8 + ($random(seed) & 7));
      ea        = (s == 0) ? 10'h3ff : 10'($random(seed));
      bus(1'b1, 8'h00, {4'h1, 2'(s), ea});
      bus(1'b0, 8'h08, 16'h0);
      chk_reg("busy", (s >= 2) ? 32'h80 : 32'h0, q & 32'h80);
      for (k = 0; k < 50 && q[7] !== 1'b0; k++) bus(1'b0, 8'h08, 16'h0);
      chk_reg("busy clear", 32'h0, q & 32'h80);
      wait_count(8'(s + 5));
      repeat (2) @(posedge clk);
      {top_exp, w[3], w[2], w[1], w[0]} = rd_value;
      chk_reg("direction", 32'h1, {31'h0, seen_rd});
      chk_reg("table", 32'(s), {30'h0, seen_sel});
      chk_reg("entry", {22'h0, ea}, {22'h0, seen_addr});
      bus(1'b1, 8'h08, 16'hff7f);
      bus(1'b0, 8'h08, 16'h0);
      chk_reg("top", {29'h0, top_exp}, q);
      chk_words();
    end
    // Both event kinds have fired; mask, raise and clear the interrupt
    bus(1'b0, 8'h30, 16'h0);
    chk_reg("status", 32'h3, q);
    chk_reg("irq masked", 32'h0, {31'h0, irq});
    bus(1'b1, 8'h38, 16'h0001);
    repeat (2) @(posedge clk);
    chk_reg("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h30, 16'h0001);
    repeat (2) @(posedge clk);
    chk_reg("irq cleared", 32'h0, {31'h0, irq});
    bus(1'b0, 8'h30, 16'h0);
    chk_reg("status", 32'h2, q);
    bus(1'b1, 8'h38, 16'h0003);
    repeat (2) @(posedge clk);
    chk_reg("irq", 32'h1, {31'h0, irq});
    bus(1'b1, 8'h30, 16'h0002);
    repeat (2) @(posedge clk);
    chk_reg("irq cleared", 32'h0, {31'h0, irq});
    test_done();
  end
endmodule : indirect_table_access_tb_top
